// ===== tcspc_pkg.sv
// Shared constants and types of the Type-C source protection controller.
package tcspc_pkg;
   localparam int unsigned CLK_HZ            = 50_000_000;
   localparam int unsigned SOFT_START_US     = 1000;
   localparam int unsigned DISCHARGE_MS      = 300;
   localparam int unsigned OV_DEB_US         = 10;
   localparam int unsigned UV_DEB_US         = 1000;
   localparam int unsigned OC_DEB_US         = 2500;
   localparam int unsigned FOC_DEB_US        = 1;
   localparam int unsigned ATTACH_DEB_US     = 150;
   localparam int unsigned SOFT_START_CYC    = SOFT_START_US * (CLK_HZ / 1_000_000);
   localparam int unsigned DISCHARGE_CYC     = DISCHARGE_MS * (CLK_HZ / 1000);
   localparam int unsigned OV_DEB_CYC        = OV_DEB_US * (CLK_HZ / 1_000_000);
   localparam int unsigned UV_DEB_CYC        = UV_DEB_US * (CLK_HZ / 1_000_000);
   localparam int unsigned OC_DEB_CYC        = OC_DEB_US * (CLK_HZ / 1_000_000);
   localparam int unsigned FOC_DEB_CYC       = FOC_DEB_US * (CLK_HZ / 1_000_000);
   localparam int unsigned ATTACH_DEB_CYC    = ATTACH_DEB_US * (CLK_HZ / 1_000_000);
   localparam int unsigned CNT_W             = 24;
   // Rp advertisement codes: 1 selects 3 A (default), 0 selects 1.5 A.
   localparam logic        RP_ADV_3A         = 1'b1;
   localparam logic        RP_ADV_1P5A       = 1'b0;
   // Fuse defaults: over-voltage option 0 is 120 %, current option 0 is 120 %.
   localparam logic        OV_FUSE_DEFAULT   = 1'b0;
   localparam logic [1:0]  OC_FUSE_DEFAULT   = 2'h0;
   typedef enum logic [2:0] {
      TCSPC_STANDBY,
      TCSPC_ATTACH_DEB,
      TCSPC_SOFT_START,
      TCSPC_POWERED,
      TCSPC_DISCHARGE,
      TCSPC_FAULT_HOLD
   } tcspc_state_t;
endpackage

// ===== tcspc_ctrl.sv
// Type-C source protection controller: attach, soft start, discharge, D+/D- mode, faults.
`timescale 1ns/1ps
`default_nettype none
module tcspc_ctrl
   import tcspc_pkg::*;
#(
   parameter int unsigned SOFT_START_CYCLES = SOFT_START_CYC,
   parameter int unsigned DISCHARGE_CYCLES  = DISCHARGE_CYC,
   parameter int unsigned UV_DEB_CYCLES     = UV_DEB_CYC,
   parameter int unsigned OC_DEB_CYCLES     = OC_DEB_CYC,
   parameter int unsigned ATTACH_CYCLES     = ATTACH_DEB_CYC
) (
   input  wire logic       MCLK,
   input  wire logic       RESETN,
   input  wire logic       RP_SELECT_3A,
   input  wire logic       OV_FUSE_SEL,
   input  wire logic [1:0] OC_FUSE_SEL,
   input  wire logic       UV_GUARD_EN,
   input  wire logic       CC_ATTACHED,
   input  wire logic       OVERVOLTAGE_GUARD,
   input  wire logic       UNDERVOLTAGE_GUARD,
   input  wire logic       OVERCURRENT_GUARD,
   input  wire logic       FAST_OVERCURRENT,
   input  wire logic       THERMAL_HOT,
   input  wire logic       THERMAL_COOL,
   input  wire logic       DP_BELOW_ENTRY,
   input  wire logic       DM_BELOW_ENTRY,
   output logic            RP_ENABLE,
   output logic            RP_ADV_3A_SEL,
   output logic            OV_THRESH_SEL,
   output logic [1:0]      OC_THRESH_SEL,
   output logic            SWITCH_ON,
   output logic            SOFT_START_ACTIVE,
   output logic            SUPPLY_INPUT_DISCHARGE,
   output logic            VBUS_DISCHARGE,
   output logic            DIVIDER_BIAS_MODE,
   output logic            SHORTED_LINES_MODE,
   output logic            FAULT_ACTIVE
);
   // Synchronisers for every analog comparator and strap input.
   localparam int unsigned NSYNC = 13;
   logic [NSYNC-1:0] raw_in;
   logic [NSYNC-1:0] sync_a;
   logic [NSYNC-1:0] sync_b;
   assign raw_in = {RP_SELECT_3A, OV_FUSE_SEL, OC_FUSE_SEL, UV_GUARD_EN, CC_ATTACHED,
                    OVERVOLTAGE_GUARD, UNDERVOLTAGE_GUARD, OVERCURRENT_GUARD,
                    FAST_OVERCURRENT, THERMAL_HOT, DP_BELOW_ENTRY, DM_BELOW_ENTRY};

   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         sync_a <= '0;
         sync_b <= '0;
      end else begin
         sync_a <= raw_in;
         sync_b <= sync_a;
      end
   end

   logic cool_a;
   logic cool_s;
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         cool_a <= 1'b0;
         cool_s <= 1'b0;
      end else begin
         cool_a <= THERMAL_COOL;
         cool_s <= cool_a;
      end
   end

   logic       s_rp3a;
   logic       s_ovsel;
   logic [1:0] s_ocsel;
   logic       s_uven;
   logic       s_cc;
   logic       s_ov;
   logic       s_uv;
   logic       s_oc;
   logic       s_foc;
   logic       s_hot;
   logic       s_dp_low;
   logic       s_dm_low;
   assign {s_rp3a, s_ovsel, s_ocsel, s_uven, s_cc, s_ov, s_uv, s_oc, s_foc, s_hot,
           s_dp_low, s_dm_low} = sync_b;

   // Debounce filters: a condition counts only after it has held steadily.
   localparam int unsigned NDEB = 5;
   localparam int unsigned DEB_OV  = 0;
   localparam int unsigned DEB_UV  = 1;
   localparam int unsigned DEB_OC  = 2;
   localparam int unsigned DEB_FOC = 3;
   localparam int unsigned DEB_CC  = 4;
   logic [NDEB-1:0] deb_raw;
   logic [NDEB-1:0] deb_ok;
   logic [CNT_W-1:0] deb_len [NDEB];
   assign deb_raw = {s_cc, s_foc, s_oc, s_uv & s_uven, s_ov};
   assign deb_len[DEB_OV]  = CNT_W'(OV_DEB_CYC);
   assign deb_len[DEB_UV]  = CNT_W'(UV_DEB_CYCLES);
   assign deb_len[DEB_OC]  = CNT_W'(OC_DEB_CYCLES);
   assign deb_len[DEB_FOC] = CNT_W'(FOC_DEB_CYC);
   assign deb_len[DEB_CC]  = CNT_W'(ATTACH_CYCLES);

   generate
      for (genvar g = 0; g < NDEB; g++) begin : g_deb
         logic [CNT_W-1:0] cnt;
         always_ff @(posedge MCLK) begin
            if (!RESETN) begin
               cnt <= '0;
            end else if (!deb_raw[g]) begin
               cnt <= '0;
            end else if (cnt < deb_len[g]) begin
               cnt <= cnt + 1'b1;
            end
         end
         assign deb_ok[g] = deb_raw[g] && (cnt >= deb_len[g]);
      end
   endgenerate

   // Thermal cutoff latches with hysteresis: trips hot at once, clears only when cool.
   logic thermal_cutoff;
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         thermal_cutoff <= 1'b0;
      end else if (s_hot) begin
         thermal_cutoff <= 1'b1;
      end else if (cool_s) begin
         thermal_cutoff <= 1'b0;
      end
   end

   logic fault_now;
   logic fault_clear;
   assign fault_now = deb_ok[DEB_OV] | deb_ok[DEB_UV] | deb_ok[DEB_OC] | deb_ok[DEB_FOC]
                      | thermal_cutoff | s_hot;
   // Slow over-current has no lasting condition; the fresh attach cycle is its recovery.
   assign fault_clear = !s_ov && !(s_uv && s_uven) && !s_foc && !thermal_cutoff && !s_hot;

   tcspc_state_t     state;
   logic [CNT_W-1:0] tmr;

   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         state <= TCSPC_STANDBY;
         tmr   <= '0;
      end else begin
         case (state)
            TCSPC_STANDBY: begin
               tmr <= '0;
               if (!fault_now && deb_ok[DEB_CC]) begin
                  state <= TCSPC_SOFT_START;
               end
            end
            TCSPC_ATTACH_DEB: begin
               state <= TCSPC_STANDBY;
            end
            TCSPC_SOFT_START: begin
               tmr <= tmr + 1'b1;
               if (fault_now || !s_cc) begin
                  state <= TCSPC_DISCHARGE;
                  tmr   <= '0;
               end else if (tmr >= CNT_W'(SOFT_START_CYCLES - 1)) begin
                  state <= TCSPC_POWERED;
                  tmr   <= '0;
               end
            end
            TCSPC_POWERED: begin
               if (fault_now || !s_cc) begin
                  state <= TCSPC_DISCHARGE;
                  tmr   <= '0;
               end
            end
            TCSPC_DISCHARGE: begin
               tmr <= tmr + 1'b1;
               if (tmr >= CNT_W'(DISCHARGE_CYCLES - 1)) begin
                  state <= TCSPC_FAULT_HOLD;
                  tmr   <= '0;
               end
            end
            TCSPC_FAULT_HOLD: begin
               if (fault_clear) begin
                  state <= TCSPC_STANDBY;
               end
            end
            default: begin
               state <= TCSPC_STANDBY;
               tmr   <= '0;
            end
         endcase
      end
   end

   // D+/D- protocol selection; a new attach starts in divider bias unless a line goes low before POWERED.
   logic shorted;
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         shorted <= 1'b0;
      end else if (state == TCSPC_STANDBY) begin
         shorted <= 1'b0;
      end else if (s_dp_low || s_dm_low) begin
         shorted <= 1'b1;
      end
   end

   // The switch may conduct only in a live state, with the sink present and no fault.
   // Gating here as well as in the state machine cuts the switch one cycle earlier.
   function automatic logic switch_allowed(input tcspc_state_t st,
                                           input logic         flt,
                                           input logic         cc);
      switch_allowed = (st == TCSPC_SOFT_START || st == TCSPC_POWERED) && !flt && cc;
   endfunction

   // Rp stays on from the first cycle after reset; only its strength follows the strap.
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         RP_ENABLE     <= 1'b0;
         RP_ADV_3A_SEL <= RP_ADV_3A;
      end else begin
         RP_ENABLE     <= 1'b1;
         RP_ADV_3A_SEL <= s_rp3a ? RP_ADV_3A : RP_ADV_1P5A;
      end
   end

   // Fuse options are passed through; the analog comparators apply the thresholds.
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         OV_THRESH_SEL <= OV_FUSE_DEFAULT;
         OC_THRESH_SEL <= OC_FUSE_DEFAULT;
      end else begin
         OV_THRESH_SEL <= s_ovsel;
         OC_THRESH_SEL <= s_ocsel;
      end
   end

   // The ramp flag drops together with the switch, so a fault in mid-ramp never leaves
   // the ramp driver active on an open switch.
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         SWITCH_ON         <= 1'b0;
         SOFT_START_ACTIVE <= 1'b0;
      end else begin
         SWITCH_ON         <= switch_allowed(state, fault_now, s_cc);
         SOFT_START_ACTIVE <= (state == TCSPC_SOFT_START)
                              && switch_allowed(state, fault_now, s_cc);
      end
   end

   // Both discharge paths always move together.
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         SUPPLY_INPUT_DISCHARGE <= 1'b0;
         VBUS_DISCHARGE         <= 1'b0;
      end else begin
         SUPPLY_INPUT_DISCHARGE <= (state == TCSPC_DISCHARGE);
         VBUS_DISCHARGE         <= (state == TCSPC_DISCHARGE);
      end
   end

   // A low line takes effect in the same cycle as the latch, so the two modes never
   // overlap while the latch catches up.
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         DIVIDER_BIAS_MODE  <= 1'b0;
         SHORTED_LINES_MODE <= 1'b0;
      end else begin
         DIVIDER_BIAS_MODE  <= (state == TCSPC_POWERED) && !shorted
                               && !s_dp_low && !s_dm_low;
         SHORTED_LINES_MODE <= (state == TCSPC_POWERED) && (shorted || s_dp_low
                               || s_dm_low);
      end
   end

   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         FAULT_ACTIVE <= 1'b0;
      end else begin
         FAULT_ACTIVE <= fault_now;
      end
   end
endmodule
`default_nettype wire

// ===== tcspc_ctrl_sva.sv
// Port assertions of the source protection controller.
`timescale 1ns/1ps
`default_nettype none
module tcspc_ctrl_chk #(parameter int unsigned DISCHARGE_CYCLES = 30) (
   input wire logic       MCLK,
   input wire logic       RESETN,
   input wire logic       RP_SELECT_3A,
   input wire logic [1:0] OC_FUSE_SEL,
   input wire logic       CC_ATTACHED,
   input wire logic       THERMAL_HOT,
   input wire logic       RP_ADV_3A_SEL,
   input wire logic [1:0] OC_THRESH_SEL,
   input wire logic       SWITCH_ON,
   input wire logic       SOFT_START_ACTIVE,
   input wire logic       SUPPLY_INPUT_DISCHARGE,
   input wire logic       VBUS_DISCHARGE,
   input wire logic       DIVIDER_BIAS_MODE,
   input wire logic       SHORTED_LINES_MODE,
   input wire logic       FAULT_ACTIVE
);
   // The discharge time is far too long to unroll, so a counter measures it.
   int unsigned dis_cnt;
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         dis_cnt <= 0;
      end else if (VBUS_DISCHARGE) begin
         dis_cnt <= dis_cnt + 1;
      end else begin
         dis_cnt <= 0;
      end
   end
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RESETN);
   sequence dis_end;
      $fell(VBUS_DISCHARGE);
   endsequence
   dis_pair_a: assert property (SUPPLY_INPUT_DISCHARGE == VBUS_DISCHARGE)
      else $error("discharge paths differ");
   dis_off_a: assert property (VBUS_DISCHARGE |-> !SWITCH_ON)
      else $error("switch on during discharge");
   dis_len_a: assert property (dis_end |-> dis_cnt == DISCHARGE_CYCLES)
      else $error("discharge length wrong");
   rp_adv_a: assert property (RP_SELECT_3A [*5] |-> RP_ADV_3A_SEL)
      else $error("3A advert missing");
   oc_sel_a: assert property ($stable(OC_FUSE_SEL) [*5] |-> OC_THRESH_SEL == OC_FUSE_SEL)
      else $error("current limit option not passed");
   mode_one_a: assert property (!(DIVIDER_BIAS_MODE && SHORTED_LINES_MODE))
      else $error("both line modes active");
   short_keep_a: assert property ($fell(SHORTED_LINES_MODE) |-> !SWITCH_ON)
      else $error("shorted lines dropped while powered");
   hot_off_a: assert property (THERMAL_HOT [*5] |-> !SWITCH_ON)
      else $error("switch on while hot");
   detach_off_a: assert property (!CC_ATTACHED [*6] |-> !SWITCH_ON)
      else $error("switch on after detach");
   on_attach_a: assert property ($rose(SWITCH_ON) |-> $past(CC_ATTACHED, 4) && !FAULT_ACTIVE)
      else $error("switch on without attach");
   ss_on_a: assert property (SOFT_START_ACTIVE |-> SWITCH_ON)
      else $error("soft start without switch");
endmodule
bind tcspc_ctrl tcspc_ctrl_chk #(.DISCHARGE_CYCLES(DISCHARGE_CYCLES)) u_chk (
   .MCLK(MCLK), .RESETN(RESETN), .RP_SELECT_3A(RP_SELECT_3A), .OC_FUSE_SEL(OC_FUSE_SEL),
   .CC_ATTACHED(CC_ATTACHED), .THERMAL_HOT(THERMAL_HOT), .RP_ADV_3A_SEL(RP_ADV_3A_SEL),
   .OC_THRESH_SEL(OC_THRESH_SEL), .SWITCH_ON(SWITCH_ON), .SOFT_START_ACTIVE(SOFT_START_ACTIVE),
   .SUPPLY_INPUT_DISCHARGE(SUPPLY_INPUT_DISCHARGE), .VBUS_DISCHARGE(VBUS_DISCHARGE),
   .DIVIDER_BIAS_MODE(DIVIDER_BIAS_MODE), .SHORTED_LINES_MODE(SHORTED_LINES_MODE),
   .FAULT_ACTIVE(FAULT_ACTIVE));
`default_nettype wire

// ===== tcspc_sink.sv
// Behavioural model of the attached sink on CC and D+/D-.
`timescale 1ns/1ps
`default_nettype none
module tcspc_sink (
   input  wire logic MCLK,
   input  wire logic plugged,
   input  wire logic pull_dp,
   input  wire logic SHORTED_LINES_MODE,
   output var logic  CC_ATTACHED,
   output var logic  DP_BELOW_ENTRY,
   output var logic  DM_BELOW_ENTRY
);
   initial {CC_ATTACHED, DP_BELOW_ENTRY, DM_BELOW_ENTRY} = 3'h0;
   // Shorted lines tie D- to D+, so a pull on D+ shows on both.
   always @(posedge MCLK) begin
      CC_ATTACHED <= plugged;
      DP_BELOW_ENTRY <= pull_dp;
      DM_BELOW_ENTRY <= pull_dp && SHORTED_LINES_MODE;
   end
endmodule
`default_nettype wire

// ===== tcspc_ctrl_test.sv
// Self-checking bench of the source protection controller.
`timescale 1ns/1ps
`default_nettype none
module tcspc_ctrl_test;
   import tcspc_pkg::*;
   localparam int SS = 20;
   localparam int DIS = 30;
   logic       mclk, resetn, rp_sel, ov_fuse, uv_en, plugged, pull_dp, cc, dp, dm;
   logic       rp_en, rp_adv, ov_thr, sw, ss_act, dis_in, dis_vb, bias, short_m, fault;
   logic [1:0] oc_fuse, oc_thr;
   logic [4:0] flt;
   int         n_fail, checks_done, cycles, n;
   tcspc_ctrl #(.SOFT_START_CYCLES(SS), .DISCHARGE_CYCLES(DIS), .UV_DEB_CYCLES(10),
      .OC_DEB_CYCLES(10), .ATTACH_CYCLES(5)) u_dut (.MCLK(mclk), .RESETN(resetn),
      .RP_SELECT_3A(rp_sel), .OV_FUSE_SEL(ov_fuse), .OC_FUSE_SEL(oc_fuse), .UV_GUARD_EN(uv_en),
      .CC_ATTACHED(cc), .OVERVOLTAGE_GUARD(flt[0]), .UNDERVOLTAGE_GUARD(flt[1]),
      .OVERCURRENT_GUARD(flt[2]), .FAST_OVERCURRENT(flt[3]), .THERMAL_HOT(flt[4]),
      .THERMAL_COOL(!flt[4]), .DP_BELOW_ENTRY(dp), .DM_BELOW_ENTRY(dm), .RP_ENABLE(rp_en),
      .RP_ADV_3A_SEL(rp_adv), .OV_THRESH_SEL(ov_thr), .OC_THRESH_SEL(oc_thr), .SWITCH_ON(sw),
      .SOFT_START_ACTIVE(ss_act), .SUPPLY_INPUT_DISCHARGE(dis_in), .VBUS_DISCHARGE(dis_vb),
      .DIVIDER_BIAS_MODE(bias), .SHORTED_LINES_MODE(short_m), .FAULT_ACTIVE(fault));
   tcspc_sink u_sink (.MCLK(mclk), .plugged(plugged), .pull_dp(pull_dp),
      .SHORTED_LINES_MODE(short_m), .CC_ATTACHED(cc), .DP_BELOW_ENTRY(dp), .DM_BELOW_ENTRY(dm));
   task automatic check(input logic got, input logic exp, input string msg);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask
   function automatic logic pick(input int s);
      case (s)
         0: pick = ss_act;
         1: pick = sw;
         2: pick = dis_vb;
         default: pick = short_m;
      endcase
   endfunction
   // The count n doubles as a duration measure for the level just left.
   task automatic wait_for(input int s, input logic v);
      n = 0;
      while (pick(s) !== v && n < 1000) begin
         @(posedge mclk);
         #1;
         n++;
      end
      check(pick(s), v, "wait ran out");
   endtask
   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic fault_run(input int k);
      wait_for(1, 1);
      @(posedge mclk);
      flt[k] <= 1'b1;
      wait_for(1, 0);
      check(fault, 1'b1, "fault flag");
      wait_for(2, 1);
      check(dis_in, 1'b1, "supply input discharge");
      wait_for(2, 0);
      check(n inside {[DIS - 2:DIS + 2]}, 1'b1, "discharge length");
      @(posedge mclk);
      flt[k] <= 1'b0;
      wait_for(0, 1);
      $display("fault %0d test done", k);
   endtask
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         report_and_stop();
      end
   end
   initial begin
      {resetn, rp_sel, ov_fuse, uv_en, plugged, pull_dp, flt, oc_fuse} = '0;
      n_fail = 0;
      checks_done = 0;
      cycles = 0;
      repeat (4) @(posedge mclk);
      #1;
      check(rp_adv, 1'b1, "3A default");
      @(posedge mclk);
      resetn <= 1'b1;
      rp_sel <= 1'b1;
      plugged <= 1'b1;
      wait_for(0, 1);
      check(sw, 1'b1, "switch at soft start");
      wait_for(0, 0);
      check(n inside {[SS - 1:SS + 1]}, 1'b1, "soft start length");
      check(bias, 1'b1, "divider bias");
      check(rp_en && rp_adv, 1'b1, "rp 3A advert");
      check(oc_thr == OC_FUSE_DEFAULT && ov_thr == OV_FUSE_DEFAULT, 1'b1, "fuses");
      @(posedge mclk);
      pull_dp <= 1'b1;
      wait_for(3, 1);
      check(bias, 1'b0, "bias sources removed");
      @(posedge mclk);
      pull_dp <= 1'b0;
      flt[1] <= 1'b1;
      repeat (40) @(posedge mclk);
      #1;
      check(sw, 1'b1, "under-voltage ignored when disabled");
      $display("attach test done");
      @(posedge mclk);
      flt[1] <= 1'b0;
      uv_en <= 1'b1;
      for (int k = 0; k < 5; k++)
         fault_run(k);
      @(posedge mclk);
      plugged <= 1'b0;
      wait_for(2, 1);
      check(sw, 1'b0, "detach turns off");
      @(posedge mclk);
      oc_fuse <= 2'h3;
      ov_fuse <= 1'b1;
      rp_sel <= 1'b0;
      repeat (6) @(posedge mclk);
      #1;
      check(oc_thr == 2'h3 && ov_thr == 1'b1, 1'b1, "fuse options");
      check(rp_adv, 1'b0, "1.5A advert");
      $display("option test done");
      report_and_stop();
   end
endmodule
`default_nettype wire
